// File: core/ptb_pkg.sv
`default_nettype none
package ptb_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] PTB_OFS_SRC = 8'h00;
  localparam logic [7:0] PTB_OFS_TICK0 = 8'h04;
  localparam logic [7:0] PTB_OFS_TICK1 = 8'h08;
  localparam logic [7:0] PTB_OFS_INTC = 8'h0C;
  localparam logic [7:0] PTB_OFS_EVT = 8'h10;
  localparam logic [7:0] PTB_OFS_MASK = 8'h14;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int PTB_RUN_BIT = 7;
  localparam int PTB_PER_LSB = 0;
  localparam int PTB_PER_W = 3;
  localparam int PTB_SRC_W = 2;
  localparam int PTB_GIE_BIT = 0;
  localparam int PTB_IE0_BIT = 1;
  localparam int PTB_IE1_BIT = 2;
  localparam int PTB_FLAG0_BIT = 4;
  localparam int PTB_FLAG1_BIT = 5;

  // ----------------------------------------
  // Reset values and timing counts
  // ----------------------------------------
  localparam logic [1:0] PTB_SRC_RST = 2'h0;
  localparam logic [2:0] PTB_PER_RST = 3'h0;
  localparam logic [1:0] PTB_MASK_RST = 2'h0;
  localparam logic [1:0] PTB_DIV4_LAST = 2'h3;
  localparam logic [3:0] PTB_TICK1_SHIFT = 4'h4;
  localparam int PTB_CNT_W = 11;

  // Prescaler source codes
  localparam logic [1:0] PTB_SRC_SYS = 2'h0;
  localparam logic [1:0] PTB_SRC_SYS4 = 2'h1;

  // Mask of a power-of-two period: 2**shift - 1
  function automatic logic [PTB_CNT_W-1:0] ptb_period_mask(
    input logic [3:0] shift
  );
    logic [PTB_CNT_W:0] one;
    one = {{PTB_CNT_W{1'b0}}, 1'b1} << shift;
    return one[PTB_CNT_W-1:0] - {{(PTB_CNT_W-1){1'b0}}, 1'b1};
  endfunction

endpackage
`default_nettype wire

// File: core/ptb_divider.sv
`timescale 1ns/1ps
`default_nettype none
module ptb_divider
  import ptb_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic tick_en,
  input wire logic [PTB_CNT_W-1:0] period_mask,
  output logic wrap
);

  typedef struct packed {
    logic [PTB_CNT_W-1:0] cnt;
  } ptb_div_s;

  ptb_div_s r_reg;
  ptb_div_s r_next;

  assign wrap = run && tick_en && (r_reg.cnt == period_mask);

  always_comb begin
    r_next = r_reg;
    if (!run) begin
      r_next.cnt = '0;
    end else if (tick_en) begin
      if (wrap) begin
        r_next.cnt = '0;
      end else begin
        r_next.cnt = r_reg.cnt + {{(PTB_CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  div_held_clear_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !run |=> r_reg.cnt == '0)
    else $error("divider not held clear while stopped");

  div_restart_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wrap |=> r_reg.cnt == '0)
    else $error("divider did not restart after overflow");

endmodule // ptb_divider
`default_nettype wire

// File: core/ptb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ptb_top
  import ptb_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sub_clock_tick,
  input wire logic stack_full,
  input wire logic low_power_mode,
  input wire logic ret_exec,
  input wire logic return_from_interrupt_instr_exec,
  output logic vector_call,
  output logic vector_select,
  output logic stack_push_pc,
  output logic global_interrupt_enable,
  output logic wake_request,
  output logic irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] prescaler_source_field;
    logic tick0_run_enable;
    logic [2:0] tick0_period_field;
    logic tick1_run_enable;
    logic [2:0] tick1_period_field;
    logic gie;
    logic tick0_interrupt_enable;
    logic tick1_interrupt_enable;
    logic tick0_request_flag;
    logic tick1_request_flag;
    logic [1:0] evt;
    logic [1:0] mask;
    logic [1:0] div4;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic [31:0] rdata;
    logic ready;
    logic resp;
    logic call;
    logic call_sel;
    logic push;
    logic wake;
    logic irq;
  } ptb_state_s;

  ptb_state_s r_reg;
  ptb_state_s r_next;

  logic presc_tick;
  logic wrap0;
  logic wrap1;
  logic any_run;
  logic [3:0] shift0;
  logic [3:0] shift1;
  logic addr_taken;
  logic req0;
  logic req1;

  // ----------------------------------------
  // Prescaler clock selection
  // ----------------------------------------
  assign any_run = r_reg.tick0_run_enable || r_reg.tick1_run_enable;

  always_comb begin
    unique case (r_reg.prescaler_source_field)
      PTB_SRC_SYS: presc_tick = any_run;
      PTB_SRC_SYS4: presc_tick = any_run && (r_reg.div4 == PTB_DIV4_LAST);
      default: presc_tick = any_run && sub_clock_tick;
    endcase
  end

  assign shift0 = {1'b0, r_reg.tick0_period_field};
  assign shift1 = {1'b0, r_reg.tick1_period_field} + PTB_TICK1_SHIFT;

  ptb_divider u_div0 (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(r_reg.tick0_run_enable),
    .tick_en(presc_tick),
    .period_mask(ptb_period_mask(shift0)),
    .wrap(wrap0)
  );

  ptb_divider u_div1 (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(r_reg.tick1_run_enable),
    .tick_en(presc_tick),
    .period_mask(ptb_period_mask(shift1)),
    .wrap(wrap1)
  );

  // ----------------------------------------
  // Interrupt request decision
  // ----------------------------------------
  assign req0 = r_reg.tick0_request_flag && r_reg.gie &&
                r_reg.tick0_interrupt_enable && !stack_full;
  assign req1 = r_reg.tick1_request_flag && r_reg.gie &&
                r_reg.tick1_interrupt_enable && !stack_full;

  assign addr_taken = hsel && htrans[1] && hready;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.ready = 1'b1;
    r_next.resp = 1'b0;
    r_next.call = 1'b0;
    r_next.push = 1'b0;
    r_next.wake = 1'b0;

    // Prescaler divide by four, cleared while idle
    if (!any_run) begin
      r_next.div4 = '0;
    end else begin
      r_next.div4 = r_reg.div4 + 2'h1;
    end

    // Data phase write
    if (r_reg.dp_wr) begin
      unique case (r_reg.dp_addr)
        PTB_OFS_SRC: begin
          r_next.prescaler_source_field = hwdata[PTB_SRC_W-1:0];
        end
        PTB_OFS_TICK0: begin
          r_next.tick0_run_enable = hwdata[PTB_RUN_BIT];
          r_next.tick0_period_field = hwdata[PTB_PER_LSB +: PTB_PER_W];
        end
        PTB_OFS_TICK1: begin
          r_next.tick1_run_enable = hwdata[PTB_RUN_BIT];
          r_next.tick1_period_field = hwdata[PTB_PER_LSB +: PTB_PER_W];
        end
        PTB_OFS_INTC: begin
          r_next.gie = hwdata[PTB_GIE_BIT];
          r_next.tick0_interrupt_enable = hwdata[PTB_IE0_BIT];
          r_next.tick1_interrupt_enable = hwdata[PTB_IE1_BIT];
          r_next.tick0_request_flag = hwdata[PTB_FLAG0_BIT];
          r_next.tick1_request_flag = hwdata[PTB_FLAG1_BIT];
        end
        PTB_OFS_MASK: begin
          r_next.mask = hwdata[1:0];
        end
        default: begin
        end
      endcase
    end

    // Return from interrupt sets global enable
    if (return_from_interrupt_instr_exec) begin
      r_next.gie = 1'b1;
    end

    // Vectored call, first generator first
    if (req0) begin
      r_next.call = 1'b1;
      r_next.call_sel = 1'b0;
      r_next.push = 1'b1;
      r_next.tick0_request_flag = 1'b0;
      r_next.gie = 1'b0;
    end else if (req1) begin
      r_next.call = 1'b1;
      r_next.call_sel = 1'b1;
      r_next.push = 1'b1;
      r_next.tick1_request_flag = 1'b0;
      r_next.gie = 1'b0;
    end

    // Overflow sets win over any clear
    if (wrap0) begin
      r_next.tick0_request_flag = 1'b1;
    end
    if (wrap1) begin
      r_next.tick1_request_flag = 1'b1;
    end

    // Wake on rising flag
    if (low_power_mode &&
        ((r_next.tick0_request_flag && !r_reg.tick0_request_flag) ||
         (r_next.tick1_request_flag && !r_reg.tick1_request_flag))) begin
      r_next.wake = 1'b1;
    end

    // Address phase: capture and prepare read data
    r_next.dp_wr = addr_taken && hwrite;
    r_next.dp_addr = haddr[7:0];
    if (addr_taken && !hwrite) begin
      r_next.rdata = '0;
      unique case (haddr[7:0])
        PTB_OFS_SRC: begin
          r_next.rdata[PTB_SRC_W-1:0] = r_next.prescaler_source_field;
        end
        PTB_OFS_TICK0: begin
          r_next.rdata[PTB_RUN_BIT] = r_next.tick0_run_enable;
          r_next.rdata[PTB_PER_LSB +: PTB_PER_W] = r_next.tick0_period_field;
        end
        PTB_OFS_TICK1: begin
          r_next.rdata[PTB_RUN_BIT] = r_next.tick1_run_enable;
          r_next.rdata[PTB_PER_LSB +: PTB_PER_W] = r_next.tick1_period_field;
        end
        PTB_OFS_INTC: begin
          r_next.rdata[PTB_GIE_BIT] = r_next.gie;
          r_next.rdata[PTB_IE0_BIT] = r_next.tick0_interrupt_enable;
          r_next.rdata[PTB_IE1_BIT] = r_next.tick1_interrupt_enable;
          r_next.rdata[PTB_FLAG0_BIT] = r_next.tick0_request_flag;
          r_next.rdata[PTB_FLAG1_BIT] = r_next.tick1_request_flag;
        end
        PTB_OFS_EVT: begin
          r_next.rdata[1:0] = r_reg.evt;
          r_next.evt = 2'h0;
        end
        PTB_OFS_MASK: begin
          r_next.rdata[1:0] = r_next.mask;
        end
        default: begin
        end
      endcase
    end

    // Sticky event status, set wins over read clear
    r_next.evt = r_next.evt | {wrap1, wrap0};
    r_next.irq = |(r_next.evt & r_next.mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '0;
      r_reg.prescaler_source_field <= PTB_SRC_RST;
      r_reg.tick0_period_field <= PTB_PER_RST;
      r_reg.tick1_period_field <= PTB_PER_RST;
      r_reg.mask <= PTB_MASK_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign hreadyout = r_reg.ready;
  assign hresp = r_reg.resp;
  assign hrdata = r_reg.rdata;
  assign vector_call = r_reg.call;
  assign vector_select = r_reg.call_sel;
  assign stack_push_pc = r_reg.push;
  assign global_interrupt_enable = r_reg.gie;
  assign wake_request = r_reg.wake;
  assign irq = r_reg.irq;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  flag_set_a: assert property (wrap0 |=> r_reg.tick0_request_flag)
    else $error("overflow did not set first flag");

  call_cause_a: assert property (vector_call |->
    $past(r_reg.gie) && !$past(stack_full) &&
    (vector_select ? $past(r_reg.tick1_request_flag)
                   : $past(r_reg.tick0_request_flag)))
    else $error("call without its conditions");

  full_block_a: assert property (stack_full |=> !vector_call)
    else $error("call taken with full stack");

  call_order_a: assert property (req0 |=>
    vector_call && !vector_select)
    else $error("first generator not served first");

  call_clears_a: assert property (
    vector_call && !$past(return_from_interrupt_instr_exec) |-> !r_reg.gie)
    else $error("global enable not cleared on call");

  flag_clear_a: assert property (vector_call && !vector_select &&
    !$past(wrap0) |-> !r_reg.tick0_request_flag)
    else $error("serviced flag not cleared");

  src_sys_a: assert property (any_run &&
    r_reg.prescaler_source_field == PTB_SRC_SYS |-> presc_tick)
    else $error("system clock source not routed");

  stop_quiet_a: assert property (!r_reg.tick0_run_enable |-> !wrap0)
    else $error("stopped generator overflowed");

  stop1_quiet_a: assert property (
    !r_reg.tick1_run_enable |-> !wrap1)
    else $error("stopped second generator overflowed");

  tick1_min_a: assert property (wrap1 |=> !wrap1 [*8])
    else $error("second generator period too short");

  read_zero_a: assert property (addr_taken && !hwrite &&
    haddr[7:0] == PTB_OFS_TICK0 |=> hrdata[6:3] == 4'h0)
    else $error("unimplemented bits read nonzero");

  flag_hold_a: assert property (r_reg.tick0_request_flag &&
    !req0 && !r_reg.dp_wr |=> r_reg.tick0_request_flag)
    else $error("flag dropped while pending");

  evt_set_a: assert property (wrap0 |=> r_reg.evt[0])
    else $error("overflow did not set event status");

  irq_level_a: assert property (
    irq == |(r_reg.evt & r_reg.mask))
    else $error("interrupt line off its status");

  wake_rise_a: assert property (low_power_mode && wrap0 &&
    !r_reg.tick0_request_flag |=> wake_request)
    else $error("no wake on rising flag");

  wake_quiet_a: assert property (
    !low_power_mode |=> !wake_request)
    else $error("wake outside low power");

  push_only_a: assert property (stack_push_pc == vector_call)
    else $error("push not paired with call");

  return_from_interrupt_instr_sets_a: assert property (return_from_interrupt_instr_exec && !req0 && !req1 |=>
    r_reg.gie)
    else $error("return from interrupt left enable clear");

  ret_keeps_a: assert property (ret_exec && !return_from_interrupt_instr_exec &&
    !r_reg.gie && !r_reg.dp_wr |=> !r_reg.gie)
    else $error("plain return set global enable");

endmodule // ptb_top
`default_nettype wire

// File: verif/ptb_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module ptb_core_model #(
  parameter int DEPTH = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic stack_push_pc,
  input wire logic full_req,
  input wire logic use_ret,
  input wire logic slow,
  output logic stack_full,
  output logic ret_exec,
  output logic return_from_interrupt_instr_exec
);
  int depth;
  int wait_cnt;
  assign stack_full = full_req || (depth >= DEPTH);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      depth <= 0;
      wait_cnt <= 0;
      ret_exec <= 1'b0;
      return_from_interrupt_instr_exec <= 1'b0;
    end else begin
      ret_exec <= 1'b0;
      return_from_interrupt_instr_exec <= 1'b0;
      if (stack_push_pc) begin
        depth <= depth + 1;
        wait_cnt <= slow ? 6 : 2;
      end else if (wait_cnt > 0) begin
        wait_cnt <= wait_cnt - 1;
        if (wait_cnt == 1) begin
          depth <= depth - 1;
          ret_exec <= use_ret;
          return_from_interrupt_instr_exec <= !use_ret;
        end
      end
    end
  end
endmodule // ptb_core_model
`default_nettype wire

// File: verif/ptb_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ptb_tb
  import ptb_pkg::*;
;
  localparam int SUBP = 3;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hready, hreadyout, hresp, sub_clock_tick = 1'b0, low_power_mode = 1'b0;
  logic stack_full, ret_exec, return_from_interrupt_instr_exec, vector_call, vector_select;
  logic stack_push_pc, global_interrupt_enable, wake_request, irq;
  logic full_req = 1'b0, use_ret = 1'b0, slow = 1'b0;
  int miscompares = 0, num_checks = 0, cyc = 0, sc = 0, wakes = 0;
  int calls[$];
  logic sels[$];
  assign hready = hreadyout;
  always #2 hclk = ~hclk;
  ptb_top i_ptb_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .sub_clock_tick(sub_clock_tick),
    .stack_full(stack_full), .low_power_mode(low_power_mode),
    .ret_exec(ret_exec), .return_from_interrupt_instr_exec(return_from_interrupt_instr_exec),
    .vector_call(vector_call), .vector_select(vector_select),
    .stack_push_pc(stack_push_pc),
    .global_interrupt_enable(global_interrupt_enable),
    .wake_request(wake_request), .irq(irq));
  ptb_core_model i_ptb_core_model (.hclk(hclk), .hresetn(hresetn),
    .stack_push_pc(stack_push_pc), .full_req(full_req), .use_ret(use_ret),
    .slow(slow), .stack_full(stack_full), .ret_exec(ret_exec),
    .return_from_interrupt_instr_exec(return_from_interrupt_instr_exec));
  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic wcall(input int k, input int lim);
    int j;
    j = 0;
    while (calls.size() < k && j < lim) begin
      @(posedge hclk);
      j++;
    end
    chk(calls.size() >= k, 32'h1);
  endtask
  // ----------------------------------------
  // Monitors, sub clock and timeout
  // ----------------------------------------
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    sc <= (sc == SUBP - 1) ? 0 : sc + 1;
    sub_clock_tick <= (sc == SUBP - 1);
    if (hresetn) begin
      chk(stack_push_pc, vector_call);
      if (vector_call === 1'b1) begin
        calls.push_back(cyc);
        sels.push_back(vector_select);
      end
      if (wake_request === 1'b1) wakes++;
    end
    if (cyc == 60000) begin
      miscompares++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] ofs[7];
    logic [7:0] wo[5];
    logic [31:0] we[5];
    logic [31:0] r;
    int n, g, s, per, t0;
    ofs = '{PTB_OFS_SRC, PTB_OFS_TICK0, PTB_OFS_TICK1, PTB_OFS_INTC,
            PTB_OFS_EVT, PTB_OFS_MASK, 8'h18};
    wo = '{PTB_OFS_SRC, PTB_OFS_TICK0, PTB_OFS_TICK1, PTB_OFS_MASK, 8'h18};
    we = '{32'h3, 32'h87, 32'h87, 32'h3, 32'h0};
    void'($urandom(92560));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 7; i++) rc(ofs[i], 32'h0);
    chk(hresp, 1'b0);
    for (int i = 0; i < 5; i++) begin
      wr(wo[i], 32'hFFFFFFFF);
      rc(wo[i], we[i]);
      wr(wo[i], 32'h0);
    end
    wr(PTB_OFS_INTC, 32'h0);
    bus(1'b0, PTB_OFS_EVT, 32'h0, r);
    // Period per source and generator
    for (int i = 0; i < 8; i++) begin
      g = i % 2;
      s = i / 2;
      n = g ? $urandom_range(3, 0) : $urandom_range(7, 3);
      per = (1 << (n + 4 * g)) * (s == 0 ? 1 : (s == 1 ? 4 : SUBP));
      slow <= (i / 2) % 2;
      wr(PTB_OFS_SRC, s);
      wr(PTB_OFS_INTC, g ? 32'h5 : 32'h3);
      calls.delete();
      sels.delete();
      t0 = cyc;
      wr(g ? PTB_OFS_TICK1 : PTB_OFS_TICK0, 32'h80 | n);
      wcall(3, 4 * per + 60);
      chk(calls[2] - calls[1], per);
      chk(sels[0], g);
      chk(calls[0] - t0 >= per && calls[0] - t0 <= per + SUBP + 8, 1);
      wr(g ? PTB_OFS_TICK1 : PTB_OFS_TICK0, 32'h0);
      wr(PTB_OFS_INTC, 32'h0);
      bus(1'b0, PTB_OFS_EVT, 32'h0, r);
      rc(PTB_OFS_EVT, 32'h0);
    end
    // Stalled by a full stack, then plain return
    wr(PTB_OFS_SRC, 32'h0);
    full_req <= 1'b1;
    use_ret <= 1'b1;
    wr(PTB_OFS_INTC, 32'h3);
    calls.delete();
    wr(PTB_OFS_TICK0, 32'h83);
    repeat (40) @(posedge hclk);
    chk(calls.size(), 32'h0);
    rc(PTB_OFS_INTC, 32'h13);
    full_req <= 1'b0;
    wcall(1, 12);
    repeat (40) @(posedge hclk);
    chk(calls.size(), 32'h1);
    chk(global_interrupt_enable, 1'b0);
    rc(PTB_OFS_INTC, 32'h12);
    wr(PTB_OFS_TICK0, 32'h0);
    wr(PTB_OFS_INTC, 32'h0);
    use_ret <= 1'b0;
    // Status, mask and interrupt line
    wr(PTB_OFS_MASK, 32'h1);
    bus(1'b0, PTB_OFS_EVT, 32'h0, r);
    wr(PTB_OFS_TICK0, 32'h82);
    repeat (20) @(posedge hclk);
    chk(irq, 1'b1);
    wr(PTB_OFS_TICK0, 32'h0);
    rc(PTB_OFS_EVT, 32'h1);
    rc(PTB_OFS_EVT, 32'h0);
    chk(irq, 1'b0);
    wr(PTB_OFS_MASK, 32'h0);
    wr(PTB_OFS_TICK0, 32'h82);
    repeat (20) @(posedge hclk);
    chk(irq, 1'b0);
    wr(PTB_OFS_TICK0, 32'h0);
    rc(PTB_OFS_EVT, 32'h1);
    wr(PTB_OFS_INTC, 32'h0);
    // Wake on flag rise, suppressed by a preset flag
    low_power_mode <= 1'b1;
    wakes = 0;
    wr(PTB_OFS_TICK0, 32'h83);
    repeat (30) @(posedge hclk);
    chk(wakes, 32'h1);
    wr(PTB_OFS_TICK0, 32'h0);
    wr(PTB_OFS_INTC, 32'h10);
    wakes = 0;
    wr(PTB_OFS_TICK0, 32'h83);
    repeat (30) @(posedge hclk);
    chk(wakes, 32'h0);
    wr(PTB_OFS_TICK0, 32'h0);
    low_power_mode <= 1'b0;
    print_verdict();
  end
endmodule // ptb_tb
`default_nettype wire
